// ==== hdl/csc_cell_status.sv ====
`timescale 1ns/100ps
module csc_cell_status (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic tx_octet_parity_fault_i,
    input wire logic tx_cell_start_fault_i,
    input wire logic tx_fifo_overrun_flag_i,
    input wire logic rx_fifo_overrun_flag_i,
    input wire logic cell_transmitted_i,
    input wire logic duplicate_address_flag_i,
    input wire logic tx_gap_i,
    input wire logic delineation_lost_state_i,
    input wire logic header_check_uncorrectable_i,
    input wire logic header_check_fixed_i,
    input wire logic rx_hdr_valid_i,
    input wire logic [31:0] rx_hdr_i,
    output logic repeat_last_cell_enable_o,
    output logic tx_fill_idle_o,
    output logic tx_fill_repeat_o
);
    localparam int SW = csc_pkg::SNAP_W;

    typedef struct packed {
        logic [7:0] tx_stat;
        logic [7:0] rx_stat;
        logic [7:0] tx_ind;
        logic [7:0] rx_ind;
        logic [7:0] tx_en;
        logic [7:0] rx_en;
        logic [31:0] rx_val;
        logic [31:0] rx_msk;
        logic [31:0] idle_val;
        logic [31:0] idle_msk;
        logic delin_prev;
        logic [SW-1:0] idle_snap;
        logic [SW-1:0] sent_snap;
        logic [SW-1:0] arr_snap;
        logic [7:0] unm_snap;
        logic ack;
        logic [31:0] dat;
    } csc_state_t;

    csc_state_t q;
    csc_state_t next_q;

    csc_tally_if tif [csc_pkg::TALLY_N] ();

    logic take;
    logic rd;
    logic wr;
    logic [5:0] idx;
    logic m_cell;
    logic m_idle;
    logic m_unm;
    logic m_gfc;
    logic delin_edge;
    logic [7:0] tx_set;
    logic [7:0] rx_set;
    logic [7:0] rx_ind_set;

    // set wins over clear for every held bit
    function automatic logic [7:0] sticky(input logic [7:0] old,
                                          input logic [7:0] set,
                                          input logic [7:0] clr);
        sticky = set | (old & ~clr);
    endfunction

    // header compare, mask bit one means compare that bit
    function automatic logic hdr_match(input logic [31:0] hdr,
                                       input logic [31:0] val,
                                       input logic [31:0] msk);
        hdr_match = ((hdr ^ val) & msk) == 32'h00000000;
    endfunction

    // byte-lane merge for word registers
    function automatic logic [31:0] lane_wr(input logic [31:0] old,
                                            input logic [31:0] din,
                                            input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = din[b*8 +: 8];
            end
        end
        lane_wr = res;
    endfunction

    // bus request decode, one answer per request
    assign take = wb_cyc_i & wb_stb_i & ~q.ack;
    assign rd = take & ~wb_we_i;
    assign wr = take & wb_we_i;
    assign idx = wb_adr_i[7:2];

    // header classification
    assign m_cell = rx_hdr_valid_i
        & hdr_match(rx_hdr_i, q.rx_val, q.rx_msk);
    assign m_idle = rx_hdr_valid_i
        & hdr_match(rx_hdr_i, q.idle_val, q.idle_msk);
    assign m_unm = rx_hdr_valid_i & ~m_cell & ~m_idle;
    assign m_gfc = rx_hdr_valid_i
        & (rx_hdr_i[csc_pkg::GFC_HI:csc_pkg::GFC_LO] != 4'h0);
    assign delin_edge = q.delin_prev ^ delineation_lost_state_i;

    // event vectors in register bit order
    always_comb begin
        tx_set = 8'h00;
        tx_set[csc_pkg::TX_PARITY] = tx_octet_parity_fault_i;
        tx_set[csc_pkg::TX_START] = tx_cell_start_fault_i;
        tx_set[csc_pkg::TX_OVR] = tx_fifo_overrun_flag_i;
        tx_set[csc_pkg::RX_OVR] = rx_fifo_overrun_flag_i;
        tx_set[csc_pkg::TX_SENT] = cell_transmitted_i;
        tx_set[csc_pkg::TX_DUP] = duplicate_address_flag_i;
        rx_set = 8'h00;
        rx_set[csc_pkg::RX_UNFIX] = header_check_uncorrectable_i;
        rx_set[csc_pkg::RX_FIXED] = header_check_fixed_i;
        rx_set[csc_pkg::RX_CELL] = m_cell;
        rx_set[csc_pkg::RX_IDLE] = m_idle;
        rx_set[csc_pkg::RX_UNM] = m_unm;
        rx_set[csc_pkg::RX_GFC] = m_gfc;
        rx_ind_set = rx_set;
        rx_ind_set[csc_pkg::RX_DELIN] = delin_edge;
    end

    // tally drive: increments and clearing reads
    assign tif[csc_pkg::T_IDLE].inc = m_idle;
    assign tif[csc_pkg::T_DLOSS].inc = delin_edge
        & delineation_lost_state_i;
    assign tif[csc_pkg::T_SENT].inc = cell_transmitted_i;
    assign tif[csc_pkg::T_FIXED].inc = header_check_fixed_i;
    assign tif[csc_pkg::T_ARR].inc = m_cell;
    assign tif[csc_pkg::T_UNFIX].inc = header_check_uncorrectable_i;
    assign tif[csc_pkg::T_UNM].inc = m_unm;
    assign tif[csc_pkg::T_IDLE].clr = rd & (idx == csc_pkg::IDX_IDLE_L);
    assign tif[csc_pkg::T_DLOSS].clr = rd & (idx == csc_pkg::IDX_DLOSS);
    assign tif[csc_pkg::T_SENT].clr = rd & (idx == csc_pkg::IDX_SENT_L);
    assign tif[csc_pkg::T_FIXED].clr = rd & (idx == csc_pkg::IDX_FIXED);
    assign tif[csc_pkg::T_ARR].clr = rd & (idx == csc_pkg::IDX_ARR_L);
    assign tif[csc_pkg::T_UNFIX].clr = rd & (idx == csc_pkg::IDX_UNFIX);
    assign tif[csc_pkg::T_UNM].clr = rd & (idx == csc_pkg::IDX_UNM_L);

    // one saturating tally per counter
    for (genvar i = 0; i < csc_pkg::TALLY_N; i++) begin : g_tally
        csc_tally #(
            .W(csc_pkg::TALLY_W[i])
        ) u_tally (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .tally(tif[i])
        );
    end

    // next state: status, indications, writes, reads
    always_comb begin
        next_q = q;
        next_q.ack = take;
        next_q.delin_prev = delineation_lost_state_i;
        next_q.dat = 32'h00000000;
        // held events, cleared by a read of their register
        next_q.tx_stat = sticky(q.tx_stat, tx_set,
            (rd && idx == csc_pkg::IDX_TX_STAT)
            ? csc_pkg::TX_EVT_MASK : 8'h00);
        next_q.rx_stat = sticky(q.rx_stat, rx_set,
            (rd && idx == csc_pkg::IDX_RX_STAT)
            ? csc_pkg::RX_EVT_MASK : 8'h00);
        // indications latch only while enabled
        next_q.tx_ind = sticky(q.tx_ind, tx_set & q.tx_en,
            (rd && idx == csc_pkg::IDX_TX_IND)
            ? 8'hff : 8'h00);
        next_q.rx_ind = sticky(q.rx_ind, rx_ind_set & q.rx_en,
            (rd && idx == csc_pkg::IDX_RX_IND)
            ? 8'hff : 8'h00);
        // software writes
        if (wr) begin
            unique case (idx)
                csc_pkg::IDX_TX_STAT: begin
                    if (wb_sel_i[0]) begin
                        next_q.tx_stat[csc_pkg::TX_REPEAT] =
                            wb_dat_i[csc_pkg::TX_REPEAT];
                    end
                end
                csc_pkg::IDX_TX_EN: begin
                    if (wb_sel_i[0]) begin
                        next_q.tx_en = wb_dat_i[7:0] & csc_pkg::TX_EN_MASK;
                    end
                end
                csc_pkg::IDX_RX_EN: begin
                    if (wb_sel_i[0]) begin
                        next_q.rx_en = wb_dat_i[7:0] & csc_pkg::RX_EN_MASK;
                    end
                end
                csc_pkg::IDX_RX_VAL: begin
                    next_q.rx_val = lane_wr(q.rx_val, wb_dat_i, wb_sel_i);
                end
                csc_pkg::IDX_RX_MSK: begin
                    next_q.rx_msk = lane_wr(q.rx_msk, wb_dat_i, wb_sel_i);
                end
                csc_pkg::IDX_IDLE_VAL: begin
                    next_q.idle_val = lane_wr(q.idle_val, wb_dat_i,
                        wb_sel_i);
                end
                csc_pkg::IDX_IDLE_MSK: begin
                    next_q.idle_msk = lane_wr(q.idle_msk, wb_dat_i,
                        wb_sel_i);
                end
                default: begin
                end
            endcase
        end
        // reads, with snapshot of upper tally bytes
        if (rd) begin
            unique case (idx)
                csc_pkg::IDX_TX_EN: next_q.dat[7:0] = q.tx_en;
                csc_pkg::IDX_RX_EN: next_q.dat[7:0] = q.rx_en;
                csc_pkg::IDX_TX_IND: next_q.dat[7:0] = q.tx_ind;
                csc_pkg::IDX_RX_IND: next_q.dat[7:0] = q.rx_ind;
                csc_pkg::IDX_TX_STAT: next_q.dat[7:0] = q.tx_stat;
                csc_pkg::IDX_RX_STAT: begin
                    next_q.dat[7:0] = q.rx_stat;
                    next_q.dat[csc_pkg::RX_DELIN] =
                        delineation_lost_state_i;
                end
                csc_pkg::IDX_IDLE_L: begin
                    next_q.dat[7:0] = tif[csc_pkg::T_IDLE].value[7:0];
                    next_q.idle_snap =
                        tif[csc_pkg::T_IDLE].value[18:8];
                end
                csc_pkg::IDX_IDLE_M: begin
                    next_q.dat[7:0] = q.idle_snap[7:0];
                    next_q.idle_snap[7:0] = 8'h00;
                end
                csc_pkg::IDX_IDLE_H: begin
                    next_q.dat[2:0] = q.idle_snap[10:8];
                    next_q.idle_snap[10:8] = 3'h0;
                end
                csc_pkg::IDX_DLOSS: begin
                    next_q.dat[7:0] = tif[csc_pkg::T_DLOSS].value[7:0];
                end
                csc_pkg::IDX_SENT_L: begin
                    next_q.dat[7:0] = tif[csc_pkg::T_SENT].value[7:0];
                    next_q.sent_snap =
                        tif[csc_pkg::T_SENT].value[18:8];
                end
                csc_pkg::IDX_SENT_M: begin
                    next_q.dat[7:0] = q.sent_snap[7:0];
                    next_q.sent_snap[7:0] = 8'h00;
                end
                csc_pkg::IDX_SENT_H: begin
                    next_q.dat[2:0] = q.sent_snap[10:8];
                    next_q.sent_snap[10:8] = 3'h0;
                end
                csc_pkg::IDX_FIXED: begin
                    next_q.dat[7:0] = tif[csc_pkg::T_FIXED].value[7:0];
                end
                csc_pkg::IDX_ARR_L: begin
                    next_q.dat[7:0] = tif[csc_pkg::T_ARR].value[7:0];
                    next_q.arr_snap =
                        tif[csc_pkg::T_ARR].value[18:8];
                end
                csc_pkg::IDX_ARR_M: begin
                    next_q.dat[7:0] = q.arr_snap[7:0];
                    next_q.arr_snap[7:0] = 8'h00;
                end
                csc_pkg::IDX_ARR_H: begin
                    next_q.dat[2:0] = q.arr_snap[10:8];
                    next_q.arr_snap[10:8] = 3'h0;
                end
                csc_pkg::IDX_UNFIX: begin
                    next_q.dat[7:0] = tif[csc_pkg::T_UNFIX].value[7:0];
                end
                csc_pkg::IDX_UNM_L: begin
                    next_q.dat[7:0] = tif[csc_pkg::T_UNM].value[7:0];
                    next_q.unm_snap =
                        tif[csc_pkg::T_UNM].value[15:8];
                end
                csc_pkg::IDX_UNM_H: begin
                    next_q.dat[7:0] = q.unm_snap;
                    next_q.unm_snap = 8'h00;
                end
                csc_pkg::IDX_RX_VAL: next_q.dat = q.rx_val;
                csc_pkg::IDX_RX_MSK: next_q.dat = q.rx_msk;
                csc_pkg::IDX_IDLE_VAL: next_q.dat = q.idle_val;
                csc_pkg::IDX_IDLE_MSK: next_q.dat = q.idle_msk;
                default: next_q.dat = 32'h00000000;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.tx_en <= csc_pkg::TX_EN_RST;
            q.rx_en <= csc_pkg::RX_EN_RST;
            q.tx_stat <= csc_pkg::TX_STAT_RST;
            q.rx_val <= csc_pkg::WORD_RST;
            q.rx_msk <= csc_pkg::WORD_RST;
            q.idle_val <= csc_pkg::WORD_RST;
            q.idle_msk <= csc_pkg::WORD_RST;
        end else begin
            q <= next_q;
        end
    end

    // bus outputs and transmitter gap control
    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.dat;
    assign repeat_last_cell_enable_o = q.tx_stat[csc_pkg::TX_REPEAT];
    assign tx_fill_idle_o = tx_gap_i
        & ~q.tx_stat[csc_pkg::TX_REPEAT];
    assign tx_fill_repeat_o = tx_gap_i
        & q.tx_stat[csc_pkg::TX_REPEAT];

    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    delin_ind_a: assert property (
        delin_edge && q.rx_en[csc_pkg::RX_DELIN]
        |=> q.rx_ind[csc_pkg::RX_DELIN])
        else $error("delineation change not indicated");
    sent_ind_a: assert property (
        cell_transmitted_i && q.tx_en[csc_pkg::TX_SENT]
        |=> q.tx_ind[csc_pkg::TX_SENT])
        else $error("cell sent not indicated");
    ind_gate_a: assert property (
        !q.tx_en[csc_pkg::TX_DUP] && !q.tx_ind[csc_pkg::TX_DUP]
        |=> !q.tx_ind[csc_pkg::TX_DUP])
        else $error("disabled indication latched");
    ind_clear_a: assert property (
        rd && idx == csc_pkg::IDX_TX_IND && tx_set == 8'h00
        |=> q.tx_ind == 8'h00 && q.dat[7:0] == $past(q.tx_ind))
        else $error("indication read did not clear");
    fault_flag_a: assert property (
        tx_octet_parity_fault_i || tx_cell_start_fault_i
        |=> (q.tx_stat[csc_pkg::TX_PARITY]
            || !$past(tx_octet_parity_fault_i))
        && (q.tx_stat[csc_pkg::TX_START]
            || !$past(tx_cell_start_fault_i)))
        else $error("transmit fault not flagged");
    overrun_flag_a: assert property (
        rx_fifo_overrun_flag_i |=> q.tx_stat[csc_pkg::RX_OVR])
        else $error("receive overrun not flagged");
    stat_hold_a: assert property (
        q.tx_stat[csc_pkg::TX_DUP] && !(rd && idx == csc_pkg::IDX_TX_STAT)
        |=> q.tx_stat[csc_pkg::TX_DUP])
        else $error("held status lost without read");
    stat_clear_a: assert property (
        rd && idx == csc_pkg::IDX_TX_STAT && tx_set == 8'h00
        |=> (q.tx_stat & csc_pkg::TX_EVT_MASK) == 8'h00)
        else $error("status read did not clear");
    live_delin_a: assert property (
        rd && idx == csc_pkg::IDX_RX_STAT
        |=> q.dat[csc_pkg::RX_DELIN] == $past(delineation_lost_state_i))
        else $error("delineation bit not live");
    unmatched_a: assert property (
        m_unm |-> !m_cell && !m_idle ##1 q.rx_stat[csc_pkg::RX_UNM])
        else $error("unmatched cell not flagged");
    snap_a: assert property (
        rd && idx == csc_pkg::IDX_SENT_L
        |=> q.sent_snap == $past(tif[csc_pkg::T_SENT].value[18:8]))
        else $error("upper bytes not captured");
    bus_ack_a: assert property (
        take |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not single cycle");

    delin_ind_c: cover property (delin_edge && q.rx_en[csc_pkg::RX_DELIN]);
    tally_read_c: cover property (rd && idx == csc_pkg::IDX_ARR_L
        ##[1:20] rd && idx == csc_pkg::IDX_ARR_H);
    clear_race_c: cover property (rd && idx == csc_pkg::IDX_TX_STAT
        && tx_set != 8'h00);
    repeat_c: cover property (tx_fill_repeat_o);
endmodule

// ==== hdl/csc_pkg.sv ====
package csc_pkg;
    // bus geometry
    localparam int DATA_W = 32;
    localparam int ADR_W = 8;
    localparam int IDX_W = 6;
    localparam int HDR_W = 32;

    // register indices, byte address is index times four
    localparam logic [5:0] IDX_TX_EN = 6'h28;
    localparam logic [5:0] IDX_RX_EN = 6'h29;
    localparam logic [5:0] IDX_TX_IND = 6'h2c;
    localparam logic [5:0] IDX_RX_IND = 6'h2d;
    localparam logic [5:0] IDX_TX_STAT = 6'h2e;
    localparam logic [5:0] IDX_RX_STAT = 6'h2f;
    localparam logic [5:0] IDX_IDLE_L = 6'h30;
    localparam logic [5:0] IDX_IDLE_M = 6'h31;
    localparam logic [5:0] IDX_IDLE_H = 6'h32;
    localparam logic [5:0] IDX_DLOSS = 6'h33;
    localparam logic [5:0] IDX_SENT_L = 6'h34;
    localparam logic [5:0] IDX_SENT_M = 6'h35;
    localparam logic [5:0] IDX_SENT_H = 6'h36;
    localparam logic [5:0] IDX_FIXED = 6'h37;
    localparam logic [5:0] IDX_ARR_L = 6'h38;
    localparam logic [5:0] IDX_ARR_M = 6'h39;
    localparam logic [5:0] IDX_ARR_H = 6'h3a;
    localparam logic [5:0] IDX_UNFIX = 6'h3b;
    localparam logic [5:0] IDX_UNM_L = 6'h3c;
    localparam logic [5:0] IDX_UNM_H = 6'h3d;
    localparam logic [5:0] IDX_RX_VAL = 6'h20;
    localparam logic [5:0] IDX_RX_MSK = 6'h21;
    localparam logic [5:0] IDX_IDLE_VAL = 6'h22;
    localparam logic [5:0] IDX_IDLE_MSK = 6'h23;

    // transmit status bit positions
    localparam int TX_PARITY = 7;
    localparam int TX_START = 6;
    localparam int TX_OVR = 5;
    localparam int RX_OVR = 4;
    localparam int TX_SENT = 3;
    localparam int TX_DUP = 2;
    localparam int TX_REPEAT = 0;

    // receive status bit positions
    localparam int RX_DELIN = 7;
    localparam int RX_UNFIX = 6;
    localparam int RX_FIXED = 5;
    localparam int RX_CELL = 3;
    localparam int RX_IDLE = 2;
    localparam int RX_UNM = 1;
    localparam int RX_GFC = 0;

    // header flow control field
    localparam int GFC_HI = 31;
    localparam int GFC_LO = 28;

    // masks and reset values
    localparam logic [7:0] TX_EVT_MASK = 8'hfc;
    localparam logic [7:0] RX_EVT_MASK = 8'h6f;
    localparam logic [7:0] TX_EN_MASK = 8'hfc;
    localparam logic [7:0] RX_EN_MASK = 8'hef;
    localparam logic [7:0] TX_EN_RST = 8'hfc;
    localparam logic [7:0] RX_EN_RST = 8'hef;
    localparam logic [7:0] TX_STAT_RST = 8'h00;
    localparam logic [31:0] WORD_RST = 32'h00000000;

    // tallies
    localparam int TALLY_N = 7;
    localparam int TALLY_MAXW = 19;
    localparam int T_IDLE = 0;
    localparam int T_DLOSS = 1;
    localparam int T_SENT = 2;
    localparam int T_FIXED = 3;
    localparam int T_ARR = 4;
    localparam int T_UNFIX = 5;
    localparam int T_UNM = 6;
    localparam int TALLY_W [0:6] = '{19, 8, 19, 8, 19, 8, 16};
    localparam int SNAP_W = 11;
endpackage

// ==== hdl/csc_tally_if.sv ====
`timescale 1ns/100ps
interface csc_tally_if;
    logic inc;
    logic clr;
    logic [csc_pkg::TALLY_MAXW-1:0] value;
    modport owner (input inc, input clr, output value);
    modport user (output inc, output clr, input value);
endinterface

// ==== hdl/csc_tally.sv ====
`timescale 1ns/100ps
module csc_tally #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    csc_tally_if.owner tally
);
    localparam int MW = csc_pkg::TALLY_MAXW;
    localparam logic [W-1:0] FULL = {W{1'b1}};
    localparam logic [W-1:0] ONE = W'(1);

    typedef struct packed {
        logic [W-1:0] cnt;
    } csc_tally_t;

    csc_tally_t q;
    csc_tally_t next_q;

    // clear on read, a coincident event survives, stop at full
    always_comb begin
        next_q = q;
        if (tally.clr) begin
            next_q.cnt = tally.inc ? ONE : '0;
        end else if (tally.inc && q.cnt != FULL) begin
            next_q.cnt = q.cnt + ONE;
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign tally.value = MW'(q.cnt);

    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    tally_saturate_a: assert property (
        q.cnt == FULL && !tally.clr |=> q.cnt == FULL)
        else $error("tally wrapped past full");
    tally_clear_a: assert property (
        tally.clr && !tally.inc |=> q.cnt == '0)
        else $error("tally not cleared by read");
    tally_keep_a: assert property (
        tally.clr && tally.inc |=> q.cnt == ONE)
        else $error("event lost on clearing read");
    tally_full_c: cover property (q.cnt == FULL && tally.inc);
endmodule

// ==== tb/csc_atm_far_end.sv ====
`timescale 1ns/100ps
module csc_atm_far_end (
    input wire logic clk_i,
    output logic rx_hdr_valid_o,
    output logic [31:0] rx_hdr_o,
    output logic cell_transmitted_o
);
    logic [31:0] hdr_q = 32'h00000000;
    logic [31:0] idle_pat = 32'h5a5a5a5a;
    initial rx_hdr_valid_o = 1'b0;
    initial cell_transmitted_o = 1'b0;
    // header lines toggle when not valid so stale bytes never match
    always @(posedge clk_i) idle_pat <= ~idle_pat;
    assign rx_hdr_o = rx_hdr_valid_o ? hdr_q : idle_pat;
    // one header per received cell
    task send_rx(input logic [31:0] h);
        @(posedge clk_i);
        hdr_q <= h;
        rx_hdr_valid_o <= 1'b1;
        @(posedge clk_i);
        rx_hdr_valid_o <= 1'b0;
    endtask
    // back-to-back non-idle cells sent toward the line
    task send_tx(input int n);
        repeat (n) @(posedge clk_i) cell_transmitted_o <= 1'b1;
        @(posedge clk_i) cell_transmitted_o <= 1'b0;
    endtask
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, gap = 1'b1, delin = 1'b0;
    logic [7:0] adr = 8'h00, ev = 8'h00;
    logic [31:0] wdat = 32'h00000000, rdat, q, hdr;
    logic ack, rep, fidle, frep, hv, sent;
    int n_errors = 0, num_checks = 0;
    always #5 clk_i = ~clk_i;
    csc_atm_far_end far (.clk_i(clk_i), .rx_hdr_valid_o(hv),
        .rx_hdr_o(hdr), .cell_transmitted_o(sent));
    csc_cell_status DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .tx_octet_parity_fault_i(ev[7]), .tx_cell_start_fault_i(ev[6]),
        .tx_fifo_overrun_flag_i(ev[5]), .rx_fifo_overrun_flag_i(ev[4]),
        .cell_transmitted_i(sent), .duplicate_address_flag_i(ev[2]),
        .tx_gap_i(gap), .delineation_lost_state_i(delin),
        .header_check_uncorrectable_i(ev[1]),
        .header_check_fixed_i(ev[0]), .rx_hdr_valid_i(hv), .rx_hdr_i(hdr),
        .repeat_last_cell_enable_o(rep), .tx_fill_idle_o(fidle),
        .tx_fill_repeat_o(frep));
    // verdict and end of run
    task close_out;
        if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask
    // classic single cycle, held until ack is sampled, released at that edge
    task bus(input logic [5:0] i, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, i, 2'b00, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            n_errors++;
            close_out();
        end
        q = rdat;
        {cyc, stb} <= 2'b00;
    endtask
    task rd(input logic [5:0] i, input logic [31:0] e, input string nm);
        bus(i, 1'b0, 32'h00000000);
        chk(nm, e, q);
    endtask
    task pulse(input logic [7:0] v);
        @(posedge clk_i) ev <= v;
        @(posedge clk_i) ev <= 8'h00;
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(6'h2e, 32'h00, "txs");
        chk("fill", 32'h1, {rep, frep, fidle});
        bus(6'h2e, 1'b1, 32'h01);
        chk("fill", 32'h6, {rep, frep, fidle});
        gap <= 1'b0;
        @(posedge clk_i);
        chk("fill", 32'h4, {rep, frep, fidle});
        gap <= 1'b1;
        pulse(8'hf4);
        far.send_tx(3);
        rd(6'h2e, 32'hfd, "txs");
        rd(6'h2e, 32'h01, "txs");
        rd(6'h2c, 32'hfc, "txi");
        rd(6'h2c, 32'h00, "txi");
        rd(6'h34, 32'h03, "snl");
        rd(6'h35, 32'h00, "snm");
        rd(6'h36, 32'h00, "snh");
        rd(6'h34, 32'h00, "snl");
        bus(6'h28, 1'b1, 32'h00);
        pulse(8'h04);
        rd(6'h2c, 32'h00, "txi");
        rd(6'h2e, 32'h05, "txs");
        delin <= 1'b1;
        rd(6'h2f, 32'h80, "rxs");
        rd(6'h2d, 32'h80, "rxi");
        delin <= 1'b0;
        rd(6'h2d, 32'h80, "rxi");
        rd(6'h33, 32'h01, "dls");
        far.send_rx(32'h10000000);
        rd(6'h2f, 32'h0d, "rxs");
        rd(6'h38, 32'h01, "arl");
        rd(6'h30, 32'h01, "idl");
        bus(6'h21, 1'b1, 32'hffffffff);
        bus(6'h23, 1'b1, 32'hffffffff);
        far.send_rx(32'h00000005);
        rd(6'h2f, 32'h02, "rxs");
        rd(6'h3c, 32'h01, "unl");
        repeat (257) pulse(8'h03);
        rd(6'h2f, 32'h60, "rxs");
        rd(6'h37, 32'hff, "fix");
        rd(6'h3b, 32'hff, "unf");
        rd(6'h3f, 32'h00, "unmapped");
        close_out();
    end
endmodule
